// ==== design/les_consts.vh ====
`ifndef LES_CONSTS_VH
`define LES_CONSTS_VH

// Byte addresses on the register bus
`define LES_ADDR_STD_ID      8'h2C
`define LES_ADDR_LINK_ENH    8'hF4
`define LES_ADDR_SUBSYS_ID   8'hF8
`define LES_ADDR_PIN_CTRL    8'hFC
`define LES_ADDR_HOST_CTRL   8'hE0
`define LES_ADDR_STREAM      8'hE4

// Link enhancement field positions
`define LES_THR_HI           13
`define LES_THR_LO           12
`define LES_AUDIO_BIT        9
`define LES_VIDEO_BIT        8
`define LES_PRIO_BIT         7
`define LES_PROG_BIT         6
`define LES_IDLE_BIT         2
`define LES_ACCEL_BIT        1
`define LES_ENH_WMASK        32'h0000_3386

// Host control bit that gates the enhancement enables; the threshold field is not gated
`define LES_GATE_BIT         0

// Reset values
`define LES_ENH_RESET        32'h0000_1000
`define LES_ID_RESET         32'h0000_0000
`define LES_PIN_RESET        32'h0000_1010
`define LES_PIN_WMASK        32'h3131_B1B1

// Threshold codes and byte counts
`define LES_THR_2K           2'b00
`define LES_THR_1K7          2'b01
`define LES_THR_1K           2'b10
`define LES_THR_512          2'b11
`define LES_BYTES_2K         12'h800
`define LES_BYTES_1K7        12'h6C0
`define LES_BYTES_1K         12'h400
`define LES_BYTES_512        12'h200

// Stream format codes
`define LES_FMT_AUDIO        6'h10
`define LES_FMT_VIDEO        6'h00

// AXI responses
`define LES_RESP_OKAY        2'b00
`define LES_RESP_SLVERR      2'b10

`endif

// ==== design/les_regs.v ====
`include "les_consts.vh"

module les_regs (
  input  wire        clock_i,
  input  wire        resetn_i,
  // AXI4-Lite slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Serial EEPROM loader
  input  wire        eeprom_load_i,
  input  wire [31:0] eeprom_enh_i,
  input  wire [31:0] eeprom_id_i,
  // Transmit engine
  input  wire        at_underrun_i,
  input  wire        at_retry_i,
  input  wire [5:0]  tx_fmt_i,
  output wire [11:0] at_thresh_bytes_o,
  output wire        stamp_fix_o,
  output wire        prio_req_en_o,
  output wire        idle_insert_en_o,
  output wire        accel_en_o,
  output wire [15:0] subsystem_device_code_o,
  output wire [15:0] subsystem_vendor_code_o
);

  reg  [31:0] link_enhancement_ctrl;
  reg  [31:0] subsystem_identity_write;
  reg  [31:0] general_pin_ctrl;
  reg  [31:0] host_control_reg;
  reg         underrun_seen;

  reg  [7:0]  wr_addr;
  reg  [31:0] wr_data;
  reg  [3:0]  wr_strb;
  reg         aw_held;
  reg         w_held;

  wire        phy_enhance_gate;
  wire        wr_fire;
  wire        wr_hit;
  wire [31:0] next_enh;
  wire [31:0] next_id;
  wire [31:0] next_pin;
  wire [31:0] next_host;
  reg  [31:0] rd_word;
  reg         rd_hit;

  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    input [31:0] wmask;
    integer      k;
    reg   [31:0] bytes;
    begin
      bytes = 32'h0000_0000;
      for (k = 0; k < 4; k = k + 1) begin
        bytes[k*8 +: 8] = {8{strb[k]}};
      end
      merge = (old_v & ~(bytes & wmask)) | (new_v & bytes & wmask);
    end
  endfunction

  function addr_mapped;
    input [7:0] a;
    begin
      addr_mapped = (a == `LES_ADDR_LINK_ENH) || (a == `LES_ADDR_SUBSYS_ID) ||
                    (a == `LES_ADDR_PIN_CTRL) || (a == `LES_ADDR_HOST_CTRL) ||
                    (a == `LES_ADDR_STD_ID)   || (a == `LES_ADDR_STREAM);
    end
  endfunction

  // Write channel: address and data latched in either order, response after both
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
  assign wr_hit        = (wr_addr == `LES_ADDR_LINK_ENH) || (wr_addr == `LES_ADDR_SUBSYS_ID) ||
                         (wr_addr == `LES_ADDR_PIN_CTRL) || (wr_addr == `LES_ADDR_HOST_CTRL);

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      wr_addr      <= 8'h00;
      wr_data      <= 32'h0000_0000;
      wr_strb      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `LES_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held  <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Read-only alias and stream word accept no writes
        s_axi_bresp  <= wr_hit ? `LES_RESP_OKAY : `LES_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Bit 6 is absent from the write mask, so neither path can set it
  assign next_enh  = merge(link_enhancement_ctrl, wr_data, wr_strb, `LES_ENH_WMASK);
  assign next_id   = merge(subsystem_identity_write, wr_data, wr_strb, 32'hFFFF_FFFF);
  assign next_pin  = merge(general_pin_ctrl, wr_data, wr_strb, `LES_PIN_WMASK);
  assign next_host = merge(host_control_reg, wr_data, wr_strb, 32'h0000_0001);

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      link_enhancement_ctrl    <= `LES_ENH_RESET;
      subsystem_identity_write <= `LES_ID_RESET;
      general_pin_ctrl         <= `LES_PIN_RESET;
      host_control_reg         <= 32'h0000_0000;
    end else begin
      if (eeprom_load_i) begin
        // EEPROM image overrides; reserved positions are masked off
        link_enhancement_ctrl    <= eeprom_enh_i & `LES_ENH_WMASK;
        subsystem_identity_write <= eeprom_id_i;
      end else if (wr_fire) begin
        if (wr_addr == `LES_ADDR_LINK_ENH) begin
          link_enhancement_ctrl <= next_enh;
        end
        if (wr_addr == `LES_ADDR_SUBSYS_ID) begin
          subsystem_identity_write <= next_id;
        end
      end
      if (wr_fire && (wr_addr == `LES_ADDR_PIN_CTRL)) begin
        general_pin_ctrl <= next_pin;
      end
      if (wr_fire && (wr_addr == `LES_ADDR_HOST_CTRL)) begin
        host_control_reg <= next_host;
      end
    end
  end

  // Sticky until reset: a later underrun cannot re-arm the programmed value
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      underrun_seen <= 1'b0;
    end else if (at_underrun_i) begin
      underrun_seen <= 1'b1;
    end
  end

  // Read channel: one-cycle registered answer
  assign s_axi_arready = !s_axi_rvalid;

  always @* begin
    rd_word = 32'h0000_0000;
    rd_hit  = addr_mapped(s_axi_araddr);
    case (s_axi_araddr)
      `LES_ADDR_LINK_ENH:  rd_word = link_enhancement_ctrl & `LES_ENH_WMASK;
      `LES_ADDR_SUBSYS_ID: rd_word = subsystem_identity_write;
      `LES_ADDR_STD_ID:    rd_word = subsystem_identity_write;
      `LES_ADDR_PIN_CTRL:  rd_word = general_pin_ctrl;
      `LES_ADDR_HOST_CTRL: rd_word = host_control_reg;
      `LES_ADDR_STREAM:    rd_word = {15'h0000, underrun_seen, 10'h000, tx_fmt_i};
      default:             rd_word = 32'h0000_0000;
    endcase
  end

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `LES_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? `LES_RESP_OKAY : `LES_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign phy_enhance_gate = host_control_reg[`LES_GATE_BIT];

  // After underrun or on retry the store-and-forward value is forced
  les_thresh_sel u_thresh (
    .thr_code_i  (link_enhancement_ctrl[`LES_THR_HI:`LES_THR_LO]),
    .store_fwd_i (at_retry_i || underrun_seen),
    .thr_bytes_o (at_thresh_bytes_o)
  );

  les_stamp_fix u_stamp (
    .fmt_i       (tx_fmt_i),
    .audio_en_i  (phy_enhance_gate && link_enhancement_ctrl[`LES_AUDIO_BIT]),
    .video_en_i  (phy_enhance_gate && link_enhancement_ctrl[`LES_VIDEO_BIT]),
    .stamp_fix_o (stamp_fix_o)
  );

  assign prio_req_en_o    = phy_enhance_gate && link_enhancement_ctrl[`LES_PRIO_BIT];
  assign idle_insert_en_o = phy_enhance_gate && link_enhancement_ctrl[`LES_IDLE_BIT];
  assign accel_en_o       = phy_enhance_gate && link_enhancement_ctrl[`LES_ACCEL_BIT];

  assign subsystem_device_code_o = subsystem_identity_write[31:16];
  assign subsystem_vendor_code_o = subsystem_identity_write[15:0];

endmodule // les_regs

// ==== design/les_stamp_fix.v ====
`include "les_consts.vh"

module les_stamp_fix (
  input  wire [5:0] fmt_i,
  input  wire       audio_en_i,
  input  wire       video_en_i,
  output wire       stamp_fix_o
);
  // Only the two stream families listed get the timestamp fix
  assign stamp_fix_o = (audio_en_i && (fmt_i == `LES_FMT_AUDIO)) ||
                       (video_en_i && (fmt_i == `LES_FMT_VIDEO));
endmodule // les_stamp_fix

// ==== design/les_thresh_sel.v ====
`include "les_consts.vh"

module les_thresh_sel (
  input  wire [1:0]  thr_code_i,
  input  wire        store_fwd_i,
  output reg  [11:0] thr_bytes_o
);
  always @* begin
    if (store_fwd_i) begin
      thr_bytes_o = `LES_BYTES_2K;
    end else begin
      case (thr_code_i)
        `LES_THR_2K:  thr_bytes_o = `LES_BYTES_2K;
        `LES_THR_1K7: thr_bytes_o = `LES_BYTES_1K7;
        `LES_THR_1K:  thr_bytes_o = `LES_BYTES_1K;
        default:      thr_bytes_o = `LES_BYTES_512;
      endcase
    end
  end
endmodule // les_thresh_sel

// ==== verification/les_regs_checker.sv ====
`include "les_consts.vh"

module les_regs_checker (
  input wire        clock_i,
  input wire        resetn_i,
  input wire        s_axi_wvalid,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire        eeprom_load_i,
  input wire        at_underrun_i,
  input wire        at_retry_i,
  input wire [5:0]  tx_fmt_i,
  input wire [11:0] at_thresh_bytes_o,
  input wire        stamp_fix_o,
  input wire [15:0] subsystem_device_code_o
);
  timeunit 1ns;
  timeprecision 1ns;
  reg seen_ur;
  // Mirrors the sticky underrun flag, which only reset clears
  always @(posedge clock_i or negedge resetn_i)
    if (!resetn_i) seen_ur <= 1'b0;
    else if (at_underrun_i) seen_ur <= 1'b1;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  sequence quiet_s;
    !s_axi_wvalid && !eeprom_load_i;
  endsequence
  sequence rd_taken_s;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_thr_fallback: assert property ((at_retry_i || seen_ur) |-> at_thresh_bytes_o == `LES_BYTES_2K)
    else $error("threshold not 2K on retry or after underrun");
  a_thr_legal: assert property (at_thresh_bytes_o inside {12'h800, 12'h6C0, 12'h400, 12'h200})
    else $error("threshold outside the four codes");
  a_stamp_fmt: assert property (stamp_fix_o |-> tx_fmt_i inside {6'h10, 6'h00})
    else $error("stamp fix on a foreign format");
  a_id_hold: assert property (quiet_s [*3] |=> $stable(subsystem_device_code_o))
    else $error("identity changed without a write");
  a_rd_answer: assert property (rd_taken_s |=> s_axi_rvalid)
    else $error("read data late");
  a_rd_stand: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_wr_stand: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rd_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answer pending");
endmodule // les_regs_checker

bind les_regs les_regs_checker u_chk (.clock_i, .resetn_i, .s_axi_wvalid, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .eeprom_load_i,
  .at_underrun_i, .at_retry_i, .tx_fmt_i, .at_thresh_bytes_o, .stamp_fix_o, .subsystem_device_code_o);

// ==== verification/testbench.sv ====
`include "les_consts.vh"

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 0, resetn_i = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, eeprom_load_i = 0, at_underrun_i = 0, at_retry_i = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, eeprom_enh_i = 0, eeprom_id_i = 0;
  logic [3:0] s_axi_wstrb = 0;
  logic [5:0] tx_fmt_i = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [11:0] at_thresh_bytes_o;
  wire stamp_fix_o, prio_req_en_o, idle_insert_en_o, accel_en_o;
  wire [15:0] subsystem_device_code_o, subsystem_vendor_code_o;
  int mismatches = 0, checked = 0;
  les_regs u_dut (.*);
  initial forever #20 clock_i = ~clock_i;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic aw, w;
    aw = 0;
    w = 0;
    @(posedge clock_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // Each channel is released only at the edge where its own ready was seen
    while (!(aw && w)) begin
      @(posedge clock_i);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge clock_i);
    chk({30'h0, s_axi_bresp}, {30'h0, er});
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clock_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clock_i); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge clock_i);
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    s_axi_rready <= 1'b0;
  endtask
  task automatic t_reset;
    rdc(`LES_ADDR_LINK_ENH, 32'h0000_1000, `LES_RESP_OKAY);
    rdc(`LES_ADDR_SUBSYS_ID, 32'h0000_0000, `LES_RESP_OKAY);
    rdc(`LES_ADDR_PIN_CTRL, 32'h0000_1010, `LES_RESP_OKAY);
    chk({20'h0, at_thresh_bytes_o}, 32'h0000_06C0);
    $display("test reset finished");
  endtask
  task automatic t_fields;
    logic [11:0] thr [4];
    thr = '{12'h800, 12'h6C0, 12'h400, 12'h200};
    wrc(`LES_ADDR_LINK_ENH, 32'hFFFF_FFFF, 4'hF, `LES_RESP_OKAY);
    rdc(`LES_ADDR_LINK_ENH, 32'h0000_3386, `LES_RESP_OKAY);
    chk({prio_req_en_o, idle_insert_en_o, accel_en_o}, 0);
    wrc(`LES_ADDR_HOST_CTRL, 32'h0000_0001, 4'hF, `LES_RESP_OKAY);
    chk({prio_req_en_o, idle_insert_en_o, accel_en_o}, 3'b111);
    for (int c = 0; c < 4; c++) begin
      wrc(`LES_ADDR_LINK_ENH, (c << 12) | (c << 8), 4'hF, `LES_RESP_OKAY);
      chk({20'h0, at_thresh_bytes_o}, thr[c]);
      for (int f = 0; f < 3; f++) begin
        tx_fmt_i <= (f == 0) ? 6'h00 : (f == 1) ? 6'h10 : 6'h01;
        repeat (2) @(posedge clock_i);
        chk(stamp_fix_o, (c[1] && f == 1) || (c[0] && f == 0));
      end
    end
    tx_fmt_i <= 6'h10;
    wrc(`LES_ADDR_HOST_CTRL, 32'h0000_0000, 4'hF, `LES_RESP_OKAY);
    chk(stamp_fix_o, 0);
    $display("test fields finished");
  endtask
  task automatic t_ident;
    wrc(`LES_ADDR_SUBSYS_ID, 32'hA5C3_1E0F, 4'hF, `LES_RESP_OKAY);
    rdc(`LES_ADDR_STD_ID, 32'hA5C3_1E0F, `LES_RESP_OKAY);
    chk({subsystem_device_code_o, subsystem_vendor_code_o}, 32'hA5C3_1E0F);
    wrc(`LES_ADDR_SUBSYS_ID, 32'h0000_0000, 4'b0011, `LES_RESP_OKAY);
    wrc(`LES_ADDR_STD_ID, 32'h0000_0000, 4'hF, `LES_RESP_SLVERR);
    rdc(`LES_ADDR_SUBSYS_ID, 32'hA5C3_0000, `LES_RESP_OKAY);
    rdc(`LES_ADDR_STD_ID, 32'hA5C3_0000, `LES_RESP_OKAY);
    rdc(8'h40, 32'h0000_0000, `LES_RESP_SLVERR);
    $display("test ident finished");
  endtask
  task automatic t_thresh;
    wrc(`LES_ADDR_LINK_ENH, 32'h0000_3000, 4'hF, `LES_RESP_OKAY);
    at_retry_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    chk({20'h0, at_thresh_bytes_o}, 32'h0000_0800);
    at_retry_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    chk({20'h0, at_thresh_bytes_o}, 32'h0000_0200);
    at_underrun_i <= 1'b1;
    @(posedge clock_i);
    at_underrun_i <= 1'b0;
    wrc(`LES_ADDR_LINK_ENH, 32'h0000_3000, 4'hF, `LES_RESP_OKAY);
    chk({20'h0, at_thresh_bytes_o}, 32'h0000_0800);
    rdc(`LES_ADDR_STREAM, 32'h0001_0010, `LES_RESP_OKAY);
    $display("test thresh finished");
  endtask
  task automatic t_eeprom;
    @(posedge clock_i);
    eeprom_enh_i <= 32'hFFFF_FFFF;
    eeprom_id_i <= 32'h0F1E_2D3C;
    eeprom_load_i <= 1'b1;
    @(posedge clock_i);
    eeprom_load_i <= 1'b0;
    rdc(`LES_ADDR_LINK_ENH, 32'h0000_3386, `LES_RESP_OKAY);
    rdc(`LES_ADDR_STD_ID, 32'h0F1E_2D3C, `LES_RESP_OKAY);
    $display("test eeprom finished");
  endtask
  task automatic tally_and_finish;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Under two hundred cycles are expected; this bound leaves ample margin
  initial begin
    #400000;
    mismatches++;
    tally_and_finish();
  end
  initial begin
    repeat (4) @(posedge clock_i);
    resetn_i <= 1'b1;
    t_reset();
    t_fields();
    t_ident();
    t_thresh();
    t_eeprom();
    tally_and_finish();
  end
endmodule // testbench
